//--- logic/spmc_power_ctrl.v
// Purpose: power mode, pll power-down, sleep timer and flow-control pass controls
// Assumes: simple synchronous register port on the core clock; energy input from pins
// Notes: registers 0x0c..0x0f; writes to read-only bits are ignored
`include "spmc_regs.vh"

// Summary of operation
// [R01] Flow-control frames pass when the bit is one and are dropped at zero, the reset value.
// [R02] The pll bit acts only in energy-detect mode: zero lets the pll stop, one keeps it on.
// [R03] Mode 00 normal, 01 energy-detect, 10 soft power-down, 11 power-saving; resets to 00.
// [R04] Energy-detect mode sleeps only after no energy for the sleep value times 20 ms in a row.
// [R05] The eight-bit sleep value resets to 80 units, a 1.6 s default interval.
// [R06] Any energy before expiry clears the no-energy count so timing restarts from zero.
module spmc_power_ctrl #(
    parameter integer UNIT_CYCLES = `SPMC_UNIT_MS * 1000 * `SPMC_CLK_MHZ
) (
    input wire clock,
    input wire nrst,
    input wire reg_wr,
    input wire reg_rd,
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    output reg [7:0] reg_rdata,
    input wire energy_in,
    output reg pass_flow_ctrl,
    output reg [1:0] power_mode,
    output reg pll_power_down,
    output reg low_power,
    output reg soft_power_down,
    output reg power_saving
);
    // timer states
    localparam ST_AWAKE = 1'b0;
    localparam ST_ASLEEP = 1'b1;

    reg [7:0] fc_opts_reg;
    reg [7:0] fc_opts_next;
    reg pll_keep_reg;
    reg pll_keep_next;
    reg [1:0] mode_reg;
    reg [1:0] mode_next;
    reg [7:0] sleep_reg;
    reg [7:0] sleep_next;
    reg [7:0] units_reg;
    reg [7:0] units_next;
    reg state_reg;
    reg state_next;
    reg energy_s1_reg;
    reg energy_s2_reg;
    reg [7:0] rdata_next;
    reg pass_next;
    reg [1:0] mode_out_next;
    reg soft_pd_next;
    reg psave_next;
    reg low_power_next;
    reg pll_down_next;
    wire unit_tick;
    wire edetect;
    wire restart;
    wire expired;
    wire wr_fc_opts;
    wire wr_pmode;
    wire wr_sleep;

    // one write strobe per mapped register; 0x0d is read-only
    assign wr_fc_opts = reg_wr && (reg_addr == `SPMC_ADDR_FC_OPTS);
    assign wr_pmode = reg_wr && (reg_addr == `SPMC_ADDR_PMODE);
    assign wr_sleep = reg_wr && (reg_addr == `SPMC_ADDR_SLEEP);

    // timing runs only in energy-detect mode
    assign edetect = (mode_reg == `SPMC_MODE_EDETECT); // see [R04]
    assign restart = energy_s2_reg || !edetect; // see [R06]
    // a sleep value of zero enters low power at once
    assign expired = (units_reg >= sleep_reg); // see [R04]

    // energy indication is asynchronous to the core clock
    // second flop is the only reader of the first
    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            energy_s1_reg <= 1'b0;
            energy_s2_reg <= 1'b0;
        end else begin
            energy_s1_reg <= energy_in;
            energy_s2_reg <= energy_s1_reg;
        end
    end

    // one tick per sleep unit, held while counting is off
    spmc_tick_div #(
        .PERIOD(UNIT_CYCLES)
    ) u_div (
        .clock(clock),
        .nrst(nrst),
        .clear(restart),
        .tick(unit_tick)
    );

    // next register values; other addresses leave everything alone
    always @* begin
        fc_opts_next = fc_opts_reg;
        pll_keep_next = pll_keep_reg;
        mode_next = mode_reg;
        sleep_next = sleep_reg;
        if (wr_fc_opts) begin
            fc_opts_next = reg_wdata; // see [R01]
        end
        if (wr_pmode) begin
            pll_keep_next = reg_wdata[`SPMC_PMODE_PLL_BIT]; // see [R02]
            mode_next = reg_wdata[`SPMC_PMODE_MODE_HI:`SPMC_PMODE_MODE_LO]; // see [R03]
        end
        if (wr_sleep) begin
            sleep_next = reg_wdata; // see [R04]
        end
    end

    // register storage
    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            fc_opts_reg <= `SPMC_RST_FC_OPTS; // see [R01]
            pll_keep_reg <= `SPMC_RST_PLL; // see [R02]
            mode_reg <= `SPMC_RST_MODE; // see [R03]
            sleep_reg <= `SPMC_RST_SLEEP; // see [R05]
        end else begin
            fc_opts_reg <= fc_opts_next;
            pll_keep_reg <= pll_keep_next;
            mode_reg <= mode_next;
            sleep_reg <= sleep_next;
        end
    end

    // no-energy interval timer
    always @* begin
        units_next = units_reg;
        state_next = state_reg;
        case (state_reg)
            ST_AWAKE: begin
                if (restart) begin
                    units_next = 8'h00; // see [R06]
                end else if (expired) begin
                    state_next = ST_ASLEEP; // see [R04]
                end else if (unit_tick) begin
                    units_next = units_reg + 8'h01;
                end
            end
            ST_ASLEEP: begin
                if (restart) begin
                    units_next = 8'h00; // see [R06]
                    state_next = ST_AWAKE;
                end
            end
            default: begin
                units_next = 8'h00;
                state_next = ST_AWAKE;
            end
        endcase
    end

    // timer state and count
    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            units_reg <= 8'h00;
            state_reg <= ST_AWAKE;
        end else begin
            units_reg <= units_next;
            state_reg <= state_next;
        end
    end

    // output levels, one cycle behind the registers
    // pll bit clear lets the pll stop once asleep
    always @* begin
        pass_next = fc_opts_reg[`SPMC_FC_OPTS_PASS_BIT]; // see [R01]
        mode_out_next = mode_reg; // see [R03]
        soft_pd_next = (mode_reg == `SPMC_MODE_SOFT_PD); // see [R03]
        psave_next = (mode_reg == `SPMC_MODE_PSAVE); // see [R03]
        low_power_next = (state_reg == ST_ASLEEP) && edetect; // see [R04]
        pll_down_next = low_power_next && !pll_keep_reg; // see [R02]
    end

    // read data holds until the next read
    // unmapped addresses and reserved bits read as zero
    always @* begin
        rdata_next = reg_rdata;
        if (reg_rd) begin
            case (reg_addr)
                `SPMC_ADDR_FC_OPTS: begin
                    rdata_next = fc_opts_reg;
                end
                `SPMC_ADDR_FTEST: begin
                    rdata_next = `SPMC_RST_FTEST;
                end
                `SPMC_ADDR_PMODE: begin
                    rdata_next = {2'h0, pll_keep_reg, mode_reg, 3'h0};
                end
                `SPMC_ADDR_SLEEP: begin
                    rdata_next = sleep_reg;
                end
                default: begin
                    rdata_next = 8'h00;
                end
            endcase
        end
    end

    // every output straight from a flop
    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            pass_flow_ctrl <= 1'b0;
            power_mode <= `SPMC_MODE_NORMAL;
            soft_power_down <= 1'b0;
            power_saving <= 1'b0;
            low_power <= 1'b0;
            pll_power_down <= 1'b0;
            reg_rdata <= 8'h00;
        end else begin
            pass_flow_ctrl <= pass_next;
            power_mode <= mode_out_next;
            soft_power_down <= soft_pd_next;
            power_saving <= psave_next;
            low_power <= low_power_next;
            pll_power_down <= pll_down_next;
            reg_rdata <= rdata_next;
        end
    end
endmodule

//--- logic/spmc_regs.vh
// Purpose: offsets, fields, reset values and timing for the power mode control block
// Assumes: 8-bit management registers at byte offsets
// Notes: included by the power control design file by bare name
`ifndef SPMC_REGS_VH
`define SPMC_REGS_VH

`define SPMC_ADDR_FC_OPTS 8'h0c
`define SPMC_ADDR_FTEST 8'h0d
`define SPMC_ADDR_PMODE 8'h0e
`define SPMC_ADDR_SLEEP 8'h0f

`define SPMC_FC_OPTS_PASS_BIT 0
`define SPMC_PMODE_PLL_BIT 5
`define SPMC_PMODE_MODE_HI 4
`define SPMC_PMODE_MODE_LO 3

`define SPMC_RST_FC_OPTS 8'h00
`define SPMC_RST_FTEST 8'h00
`define SPMC_RST_PLL 1'h0
`define SPMC_RST_MODE 2'h0
`define SPMC_RST_SLEEP 8'h50

`define SPMC_MODE_NORMAL 2'h0
`define SPMC_MODE_EDETECT 2'h1
`define SPMC_MODE_SOFT_PD 2'h2
`define SPMC_MODE_PSAVE 2'h3

`define SPMC_UNIT_MS 20
`define SPMC_CLK_MHZ 100

`endif

//--- logic/spmc_tick_div.v
// Purpose: one-cycle enable pulse every period of clock cycles
// Assumes: single clock domain
// Notes: period must be at least 2
module spmc_tick_div #(
    parameter integer PERIOD = 2000000
) (
    input wire clock,
    input wire nrst,
    input wire clear,
    output reg tick
);
    reg [31:0] cnt_reg;

    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            cnt_reg <= 32'h0;
            tick <= 1'b0;
        end else if (clear) begin
            cnt_reg <= 32'h0;
            tick <= 1'b0;
        end else if (cnt_reg == PERIOD[31:0] - 32'h1) begin
            cnt_reg <= 32'h0;
            tick <= 1'b1;
        end else begin
            cnt_reg <= cnt_reg + 32'h1;
            tick <= 1'b0;
        end
    end
endmodule

//--- tb/spmc_power_ctrl_assertions.sv
// Purpose: port checker for the power mode block
// Assumes: one clock, nrst async low
// Notes: bound at the foot
module spmc_chk #(
    parameter integer UNIT_CYCLES = 10
) (
    input wire clock,
    input wire nrst,
    input wire reg_wr,
    input wire reg_rd,
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire [7:0] reg_rdata,
    input wire energy_in,
    input wire pass_flow_ctrl,
    input wire [1:0] power_mode,
    input wire pll_power_down,
    input wire low_power,
    input wire soft_power_down,
    input wire power_saving
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clock); endclocking
    default disable iff (!nrst);
    AST_PASS: assert property (reg_wr && reg_addr == 8'h0c |-> ## 2
        pass_flow_ctrl == $past(reg_wdata[0], 2)) else $error("pass bit");
    AST_PLL: assert property (pll_power_down |-> low_power && power_mode == 2'h1)
        else $error("pll off");
    AST_MODE: assert property (reg_wr && reg_addr == 8'h0e |-> ## 2
        power_mode == $past(reg_wdata[4:3], 2)) else $error("mode");
    AST_DECODE: assert property ($stable(power_mode) |->
        {soft_power_down, power_saving} == {power_mode == 2'h2, power_mode == 2'h3})
        else $error("decode");
    AST_SLEEP: assert property ($rose(low_power) |->
        !$past(energy_in, 4) && power_mode == 2'h1) else $error("sleep");
    AST_LOWMODE: assert property (low_power |-> power_mode == 2'h1)
        else $error("low power outside energy-detect");
    AST_WAKE: assert property (energy_in [*4] |=> !low_power) else $error("wake");
endmodule
bind spmc_power_ctrl spmc_chk #(.UNIT_CYCLES(UNIT_CYCLES)) u_chk (
    .clock(clock),
    .nrst(nrst),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata),
    .energy_in(energy_in),
    .pass_flow_ctrl(pass_flow_ctrl),
    .power_mode(power_mode),
    .pll_power_down(pll_power_down),
    .low_power(low_power),
    .soft_power_down(soft_power_down),
    .power_saving(power_saving)
);

//--- tb/spmc_power_ctrl_bench.sv
// Purpose: register bench for the power mode block
// Assumes: UNIT_CYCLES set to 10
// Notes: inputs change on the falling edge
module switch_power_mode_control_bench;
    timeunit 1ns;
    timeprecision 1ps;
    reg clock = 0, nrst = 0, reg_wr = 0, reg_rd = 0, energy_in = 1;
    reg [7:0] reg_addr = 8'h00, reg_wdata = 8'h00;
    wire [7:0] reg_rdata;
    wire pass_flow_ctrl, pll_power_down, low_power, soft_power_down, power_saving;
    wire [1:0] power_mode;
    integer err_total = 0, checked = 0, cyc = 0, i, n;
    spmc_power_ctrl #(.UNIT_CYCLES(10)) u_dut (
        .clock(clock),
        .nrst(nrst),
        .reg_wr(reg_wr),
        .reg_rd(reg_rd),
        .reg_addr(reg_addr),
        .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata),
        .energy_in(energy_in),
        .pass_flow_ctrl(pass_flow_ctrl),
        .power_mode(power_mode),
        .pll_power_down(pll_power_down),
        .low_power(low_power),
        .soft_power_down(soft_power_down),
        .power_saving(power_saving)
    );
    initial forever #5 clock = ~clock;
    task print_verdict;
        if (err_total == 0 && checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    always @(posedge clock) begin
        cyc = cyc + 1;
        if (cyc == 3000) begin
            err_total = err_total + 1;
            print_verdict;
        end
    end
    task chk(input [7:0] got, input [7:0] exp);
        checked = checked + 1;
        if (got !== exp) begin
            err_total = err_total + 1;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task wr(input [7:0] a, input [7:0] d);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1;
        @(negedge clock) reg_wr = 0;
        repeat (2) @(negedge clock);
    endtask
    task rd(input [7:0] a, input [7:0] exp);
        reg_addr = a;
        reg_rd = 1;
        @(negedge clock) reg_rd = 0;
        @(negedge clock) chk(reg_rdata, exp);
    endtask
    task idle(input integer k);
        repeat (k) @(negedge clock);
    endtask
    initial begin
        idle(4);
        nrst = 1;
        idle(1);
        rd(8'h0c, 8'h00);
        rd(8'h0e, 8'h00);
        rd(8'h0f, 8'h50);
        wr(8'h0d, 8'hff);
        rd(8'h0d, 8'h00);
        rd(8'h20, 8'h00);
        wr(8'h0e, 8'hff);
        rd(8'h0e, 8'h38);
        for (i = 1; i >= 0; i = i - 1) begin
            wr(8'h0c, i[7:0]);
            chk({7'h00, pass_flow_ctrl}, i[7:0]);
        end
        for (i = 0; i < 4; i = i + 1) begin
            wr(8'h0e, {i[4:0], 3'h0});
            chk({6'h00, power_mode}, i[7:0]);
            chk({6'h00, soft_power_down, power_saving}, {6'h00, i == 2, i == 3});
        end
        wr(8'h0f, 8'h03);
        wr(8'h0e, 8'h08);
        energy_in = 0;
        for (n = 0; low_power !== 1'b1 && n < 99; n = n + 1)
            idle(1);
        chk({7'h00, (n >= 30 && n <= 40)}, 8'h01);
        chk({7'h00, pll_power_down}, 8'h01);
        energy_in = 1;
        idle(5);
        chk({7'h00, low_power}, 8'h00);
        energy_in = 0;
        idle(20);
        energy_in = 1;
        idle(3);
        energy_in = 0;
        idle(25);
        chk({7'h00, low_power}, 8'h00);
        wr(8'h0e, 8'h28);
        idle(40);
        chk({7'h00, low_power}, 8'h01);
        chk({7'h00, pll_power_down}, 8'h00);
        print_verdict;
    end
endmodule
